// file: hdl/ilvc_cfg.svh
`ifndef ILVC_CFG_SVH
`define ILVC_CFG_SVH

// Own register offsets on the APB side
`define ILVC_REG_CTRL    8'h00
`define ILVC_REG_STATUS  8'h04
`define ILVC_REG_EPC     8'h08
`define ILVC_REG_VECTOR  8'h0C
`define ILVC_REG_DADDR   8'h10
`define ILVC_REG_DWDATA  8'h14
`define ILVC_REG_DCMD    8'h18
`define ILVC_REG_DRDATA  8'h1C

// Control register fields
`define ILVC_CTRL_IE     0
`define ILVC_CTRL_SSD    1
`define ILVC_CTRL_LM_LO  2
`define ILVC_CTRL_LM_HI  4
`define ILVC_CTRL_ERET   8

// Device command register fields
`define ILVC_DCMD_GO     0
`define ILVC_DCMD_WR     1

// Status register fields
`define ILVC_ST_EXL      0
`define ILVC_ST_BUSY     1
`define ILVC_ST_VREAD    2
`define ILVC_ST_REFUSED  3
`define ILVC_ST_LEV_LO   4
`define ILVC_ST_LEV_HI   6
`define ILVC_ST_CSS_LO   8
`define ILVC_ST_CSS_HI   10
`define ILVC_ST_PSS_LO   12
`define ILVC_ST_PSS_HI   14

// Device register map seen over the device access pins
`define ILVC_DEV_VECTOR  8'h00
`define ILVC_DEV_CLEAR   8'h04
`define ILVC_DEV_MASK    8'h08
`define ILVC_DEV_MSEL    8

// Reset and fixed values
`define ILVC_LMASK_ALL   3'h7
`define ILVC_LEV_ZERO    3'h0
`define ILVC_W32_ZERO    32'h0000_0000
`define ILVC_A8_ZERO     8'h00

`endif

// file: hdl/ilvc_pkg.sv
package ilvc_pkg;

	// Host sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_VEC_RD, ST_VEC_WAIT, ST_CLR_WR, ST_CLR_WAIT, ST_SW_WAIT
	} ilvc_state_e;

	// Device access engine states
	typedef enum logic {EN_IDLE, EN_WAIT} ilvc_eng_e;

	typedef logic [2:0] ilvc_level_t;   // Priority or mask level

	// Whole state of the host top
	typedef struct packed {
		ilvc_state_e st;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        ie;
		logic        ie_req;
		logic        shadow_set_disable;
		ilvc_level_t lmask;
		logic        exception_level_flag;
		logic [31:0] exception_return_pc;
		ilvc_level_t current_shadow_set;
		ilvc_level_t previous_shadow_set;
		logic [31:0] vector;
		logic        vread;
		ilvc_level_t acc_level;
		logic        ack;
		logic [7:0]  daddr;
		logic [31:0] dwdata;
		logic [31:0] drdata;
		logic        cmd_pend;
		logic        cmd_wr;
		logic        refused;
		logic        ereq;
		logic        ewr;
		logic [7:0]  eaddr;
		logic [31:0] ewdata;
	} ilvc_main_s;

	// Whole state of the access engine
	typedef struct packed {
		ilvc_eng_e   st;
		logic        sel;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic        done;
	} ilvc_eng_s;

endpackage : ilvc_pkg

// file: hdl/ilvc_acc_if.sv
`timescale 1ns/1ps
// Request and answer between the sequencer and the access engine
interface ilvc_acc_if;
	logic        req;    // One-cycle request pulse
	logic        wr;     // Write when high
	logic [7:0]  addr;   // Device register address
	logic [31:0] wdata;  // Write data
	logic        busy;   // Engine is in a transfer
	logic        done;   // One-cycle completion pulse
	logic [31:0] rdata;  // Read data, valid with done

	modport master (output req, wr, addr, wdata, input busy, done, rdata);
	modport engine (input req, wr, addr, wdata, output busy, done, rdata);
endinterface : ilvc_acc_if

// file: hdl/ilvc_dev_access.sv
`timescale 1ns/1ps
`include "ilvc_cfg.svh"
// Drives the device register pins, one transfer at a time
module ilvc_dev_access (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	ilvc_acc_if.engine       acc,
	output      logic        dev_sel,
	output      logic        dev_wr,
	output      logic [7:0]  dev_addr,
	output      logic [31:0] dev_wdata,
	input  wire logic [31:0] dev_rdata,
	input  wire logic        dev_ready
);
	import ilvc_pkg::*;

	ilvc_eng_s s;       // Current state
	ilvc_eng_s n;       // Next state

	// Next-state logic
	always_comb begin
		n      = s;
		n.done = 1'b0;
		case (s.st)
			EN_IDLE: begin
				// Take a request and present it on the pins
				if (acc.req) begin
					n.st    = EN_WAIT;
					n.sel   = 1'b1;
					n.wr    = acc.wr;
					n.addr  = acc.addr;
					n.wdata = acc.wdata;
				end
			end
			EN_WAIT: begin
				// Hold everything until the device answers
				if (dev_ready) begin
					n.st    = EN_IDLE;
					n.sel   = 1'b0;
					n.done  = 1'b1;
					n.rdata = dev_rdata;
				end
			end
			default: n.st = EN_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s <= '{st: EN_IDLE, sel: 1'b0, wr: 1'b0, addr: `ILVC_A8_ZERO,
			       wdata: `ILVC_W32_ZERO, rdata: `ILVC_W32_ZERO,
			       done: 1'b0};
		end else begin
			s <= n;
		end
	end

	assign dev_sel   = s.sel;
	assign dev_wr    = s.wr;
	assign dev_addr  = s.addr;
	assign dev_wdata = s.wdata;
	assign acc.busy  = (s.st != EN_IDLE);
	assign acc.done  = s.done;
	assign acc.rdata = s.rdata;

endmodule : ilvc_dev_access

// file: hdl/ilvc_host.sv
//
// Overview of operation
// - Read vector before writing mask level
// - Core sets exception flag, blocking acceptance
// - Core saves interrupted PC as return
// - Shadow enabled: switch bank to level
// - Vector upper bits hold table base
// - Core line mask bits all ones
// - Two-phase counter factors use rising edge
// - Clock-unit requests: falling edge or low
// - Configure in route order, clear first
// - Disable at core before changing settings
// - Mask write needs select bit set
// - Synchronise settings before enabling interrupts
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "ilvc_cfg.svh"
module ilvc_host (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output      logic [31:0]       prdata,
	output      logic              pready,
	output      logic              pslverr,
	input  wire logic [31:0]       core_pc,
	input  wire logic              dev_req,
	input  wire ilvc_pkg::ilvc_level_t dev_level,
	output      logic              dev_ack,
	output      logic              dev_sel,
	output      logic              dev_wr,
	output      logic [7:0]        dev_addr,
	output      logic [31:0]       dev_wdata,
	input  wire logic [31:0]       dev_rdata,
	input  wire logic              dev_ready
);
	import ilvc_pkg::*;

	ilvc_main_s  s;          // Current state
	ilvc_main_s  n;          // Next state
	ilvc_acc_if  acc ();     // Link to the access engine
	logic        hit;        // Address maps to a register
	logic [31:0] rd_val;     // Read mux result
	logic        commit;     // APB write completes this edge
	logic        can_take;   // Core may take a notification

	// Device access engine
	ilvc_dev_access u_access (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.acc       (acc),
		.dev_sel   (dev_sel),
		.dev_wr    (dev_wr),
		.dev_addr  (dev_addr),
		.dev_wdata (dev_wdata),
		.dev_rdata (dev_rdata),
		.dev_ready (dev_ready)
	);

	// Address decode and read mux
	always_comb begin
		hit    = 1'b1;
		rd_val = `ILVC_W32_ZERO;
		case (paddr)
			// Control reads back the requested enable
			`ILVC_REG_CTRL: begin
				rd_val[`ILVC_CTRL_IE]                    = s.ie_req;
				rd_val[`ILVC_CTRL_SSD]                   = s.shadow_set_disable;
				rd_val[`ILVC_CTRL_LM_HI:`ILVC_CTRL_LM_LO] = s.lmask;
			end
			// Status: handler state and command progress
			`ILVC_REG_STATUS: begin
				rd_val[`ILVC_ST_EXL]                     = s.exception_level_flag;
				// Busy covers a queued command too
				rd_val[`ILVC_ST_BUSY]                    = acc.busy
				                                         | s.cmd_pend;
				rd_val[`ILVC_ST_VREAD]                   = s.vread;
				rd_val[`ILVC_ST_REFUSED]                 = s.refused;
				rd_val[`ILVC_ST_LEV_HI:`ILVC_ST_LEV_LO]  = s.acc_level;
				rd_val[`ILVC_ST_CSS_HI:`ILVC_ST_CSS_LO]  = s.current_shadow_set;
				rd_val[`ILVC_ST_PSS_HI:`ILVC_ST_PSS_LO]  = s.previous_shadow_set;
			end
			`ILVC_REG_EPC:    rd_val = s.exception_return_pc;
			`ILVC_REG_VECTOR: rd_val = s.vector;
			// Command staging and result
			`ILVC_REG_DADDR:  rd_val[7:0] = s.daddr;
			`ILVC_REG_DWDATA: rd_val = s.dwdata;
			`ILVC_REG_DCMD:   rd_val[`ILVC_DCMD_WR] = s.cmd_wr;
			`ILVC_REG_DRDATA: rd_val = s.drdata;
			// Unmapped: error answer, zero data
			default:          hit = 1'b0;
		endcase
	end

	// Write completes at the edge that sees pready high
	// Reads need no commit: their data is taken with pready
	assign commit = psel & penable & pwrite & s.pready & hit;

	// Interrupt acceptance by the core
	// Only when enabled and not already in a handler
	// line mask check
	assign can_take = dev_req & s.ie & ~s.exception_level_flag
	                & (s.lmask == `ILVC_LMASK_ALL);

	// Next-state logic: bus slave, core state, sequencer
	always_comb begin
		n         = s;
		// Pulses and the error flag default low
		n.ack     = 1'b0;
		n.ereq    = 1'b0;
		n.pslverr = 1'b0;
		// One wait state, then answer with registered data
		if (psel & penable & ~s.pready) begin
			n.pready  = 1'b1;
			// Error answer for unmapped addresses
			n.pslverr = ~hit;
			n.prdata  = pwrite ? `ILVC_W32_ZERO : rd_val;
		end else begin
			// Between accesses pready stays low
			n.pready  = 1'b0;
		end

		// Register write effects
		if (commit) begin
			case (paddr)
				// Enable request, shadow disable, line mask
				`ILVC_REG_CTRL: begin
					n.ie_req = pwdata[`ILVC_CTRL_IE];
					n.shadow_set_disable    = pwdata[`ILVC_CTRL_SSD];
					n.lmask  = pwdata[`ILVC_CTRL_LM_HI:`ILVC_CTRL_LM_LO];
					// Disabling acts at once
					if (!pwdata[`ILVC_CTRL_IE]) begin
						n.ie = 1'b0;
					end
					// Return from handler restores bank
					if (pwdata[`ILVC_CTRL_ERET] && s.exception_level_flag) begin
						n.exception_level_flag   = 1'b0;
						n.vread = 1'b0;
						if (!s.shadow_set_disable) begin
							n.current_shadow_set = s.previous_shadow_set;
						end
					end
				end
				`ILVC_REG_STATUS: begin
					// Write one clears the refused flag
					if (pwdata[`ILVC_ST_REFUSED]) begin
						n.refused = 1'b0;
					end
				end
				// Command staging registers
				`ILVC_REG_DADDR:  n.daddr  = pwdata[7:0];
				`ILVC_REG_DWDATA: n.dwdata = pwdata;
				`ILVC_REG_DCMD: begin
					// Go is ignored while a command is pending
					if (pwdata[`ILVC_DCMD_GO] && !s.cmd_pend) begin
						if (pwdata[`ILVC_DCMD_WR] && s.ie && !s.exception_level_flag) begin
							n.refused = 1'b1;
						end else begin
							n.cmd_pend = 1'b1;
							n.cmd_wr   = pwdata[`ILVC_DCMD_WR];
						end
					end
				end
				default: begin
					// Read-only or unmapped: nothing stored
				end
			endcase
		end

		// clears land before enabling
		// The new request is used so that a disable in
		// this cycle wins over a pending enable
		// enable waits for settings to land
		if (n.ie_req && !s.ie && !n.cmd_pend && !acc.busy
		    && s.st == ST_IDLE) begin
			n.ie = 1'b1;
		end

		// Sequencer
		case (s.st)
			// Acceptance first, software commands after
			ST_IDLE: begin
				if (can_take && !acc.busy) begin
					n.exception_level_flag       = 1'b1;
					n.exception_return_pc       = core_pc;
					n.ack       = 1'b1;
					n.acc_level = dev_level;
					n.vread     = 1'b0;
					if (!s.shadow_set_disable) begin
						n.previous_shadow_set = s.current_shadow_set;
						n.current_shadow_set = dev_level;
					end
					n.st        = ST_VEC_RD;
				end else if (s.cmd_pend && !acc.busy) begin
					n.ereq   = 1'b1;
					n.ewr    = s.cmd_wr;
					n.eaddr  = s.daddr;
					n.ewdata = s.dwdata;
					if (s.cmd_wr && s.daddr == `ILVC_DEV_MASK) begin
						n.ewdata[`ILVC_DEV_MSEL] = 1'b1;
					end
					n.st     = ST_SW_WAIT;
				end
			end
			ST_VEC_RD: begin
				// vector read precedes any mask write
				n.ereq  = 1'b1;
				n.ewr   = 1'b0;
				n.eaddr = `ILVC_DEV_VECTOR;
				n.st    = ST_VEC_WAIT;
			end
			// Keep the whole vector word
			ST_VEC_WAIT: begin
				if (acc.done) begin
					n.vector = acc.rdata;
					n.vread  = 1'b1;
					n.st     = ST_CLR_WR;
				end
			end
			ST_CLR_WR: begin
				// vector value is the clear code
				n.ereq   = 1'b1;
				n.ewr    = 1'b1;
				n.eaddr  = `ILVC_DEV_CLEAR;
				n.ewdata = s.vector;
				n.st     = ST_CLR_WAIT;
			end
			// Wait for the clear to land
			ST_CLR_WAIT: begin
				if (acc.done) begin
					n.st = ST_IDLE;
				end
			end
			// Finish the software command
			ST_SW_WAIT: begin
				if (acc.done) begin
					if (!s.cmd_wr) begin
						n.drdata = acc.rdata;
					end
					n.cmd_pend = 1'b0;
					n.st       = ST_IDLE;
				end
			end
			// Unused encodings fall back to idle
			default: n.st = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// Everything clears on reset
			s <= '{st: ST_IDLE, pready: 1'b0, pslverr: 1'b0,
			       prdata: `ILVC_W32_ZERO, ie: 1'b0, ie_req: 1'b0,
			       shadow_set_disable: 1'b0, lmask: `ILVC_LEV_ZERO, exception_level_flag: 1'b0,
			       exception_return_pc: `ILVC_W32_ZERO, current_shadow_set: `ILVC_LEV_ZERO,
			       previous_shadow_set: `ILVC_LEV_ZERO, vector: `ILVC_W32_ZERO,
			       vread: 1'b0, acc_level: `ILVC_LEV_ZERO, ack: 1'b0,
			       daddr: `ILVC_A8_ZERO, dwdata: `ILVC_W32_ZERO,
			       drdata: `ILVC_W32_ZERO, cmd_pend: 1'b0,
			       cmd_wr: 1'b0, refused: 1'b0, ereq: 1'b0,
			       ewr: 1'b0, eaddr: `ILVC_A8_ZERO,
			       ewdata: `ILVC_W32_ZERO};
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign prdata    = s.prdata;
	assign pready    = s.pready;
	assign pslverr   = s.pslverr;
	assign dev_ack   = s.ack;
	// Request fields for the access engine
	assign acc.req   = s.ereq;
	assign acc.wr    = s.ewr;
	assign acc.addr  = s.eaddr;
	assign acc.wdata = s.ewdata;

endmodule : ilvc_host

// file: sim/ilvc_host_monitor.sv
`timescale 1ns/1ps
`include "ilvc_cfg.svh"
// Watches the host ports for core-side sequencing
module ilvc_host_monitor (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        dev_req,
	input wire logic        dev_ack,
	input wire logic        dev_sel,
	input wire logic        dev_wr,
	input wire logic [7:0]  dev_addr,
	input wire logic [31:0] dev_wdata,
	input wire logic        dev_ready
);
	logic blocked;  // Accepted, no return written yet
	logic unread;   // Accepted, vector not read yet
	logic ret_wr;   // Return request committed on APB
	logic vec_done; // Vector read completes at this edge

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	assign ret_wr = psel && penable && pready && pwrite
		&& paddr == `ILVC_REG_CTRL && pwdata[`ILVC_CTRL_ERET];
	assign vec_done = dev_sel && dev_ready && !dev_wr
		&& dev_addr == `ILVC_DEV_VECTOR;

	// Track acceptance until return and until the vector read
	always_ff @(posedge core_clk) begin
		if (!rst_n || ret_wr) begin
			blocked <= 1'b0;
		end else if (dev_ack) begin
			blocked <= 1'b1;
		end
		if (!rst_n || vec_done) begin
			unread <= 1'b0;
		end else if (dev_ack) begin
			unread <= 1'b1;
		end
	end

	sequence vec_rd_s;
		dev_sel && !dev_wr && dev_addr == `ILVC_DEV_VECTOR;
	endsequence
	sequence mask_wr_s;
		dev_sel && dev_wr && dev_addr == `ILVC_DEV_MASK;
	endsequence

	ack_after_req_a:
		assert property ($rose(dev_ack) |-> $past(dev_req))
		else $error("acceptance without a request");
	ack_blocked_a:
		assert property (dev_ack |-> !blocked)
		else $error("second acceptance before return");
	vec_read_first_a:
		assert property (dev_ack |-> ##[1:3] vec_rd_s)
		else $error("vector not read after acceptance");
	mask_after_read_a:
		assert property (mask_wr_s |-> !unread)
		else $error("mask written before vector read");
	mask_select_a:
		assert property (mask_wr_s |-> dev_wdata[`ILVC_DEV_MSEL])
		else $error("mask write without select bit");
	dev_hold_a:
		assert property (dev_sel && !dev_ready |=> dev_sel
			&& $stable(dev_addr) && $stable(dev_wr) && $stable(dev_wdata))
		else $error("device request changed before ready");
	dev_release_a:
		assert property (dev_sel && dev_ready |=> !dev_sel)
		else $error("device select held after ready");
	apb_wait_a:
		assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not one wait state");
	apb_err_a:
		assert property (pready && pslverr |-> prdata == `ILVC_W32_ZERO)
		else $error("error answer carries data");
endmodule : ilvc_host_monitor

// file: sim/ilvc_dev_model.sv
`timescale 1ns/1ps
`include "ilvc_cfg.svh"
// Interrupt controller with two factors: 0 rising edge, 1 high level
module ilvc_dev_model #(
	parameter logic [2:0] LEV0 = 3'h5,  // Level of factor 0
	parameter logic [2:0] LEV1 = 3'h3,  // Level of factor 1
	parameter logic [7:0] OFS0 = 8'h04, // Vector offset of factor 0
	parameter logic [7:0] OFS1 = 8'h08  // Vector offset of factor 1
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [1:0]        raw,
	input  wire logic              dev_ack,
	input  wire logic              dev_sel,
	input  wire logic              dev_wr,
	input  wire logic [7:0]        dev_addr,
	input  wire logic [31:0]       dev_wdata,
	output      logic              dev_req,
	output      ilvc_pkg::ilvc_level_t dev_level,
	output      logic [31:0]       dev_rdata,
	output      logic              dev_ready
);
	import ilvc_pkg::*;
	logic        p0;    // Sticky edge flag of factor 0
	logic        prev0; // Previous sample of factor 0
	logic        held;  // Loaded, vector not yet read
	ilvc_level_t cmask; // Current mask level
	ilvc_level_t pmask; // Previous mask level
	logic [31:0] vreg;  // Vector register
	logic [31:0] rd_q;  // Last value driven on read data
	ilvc_level_t best;  // Highest pending level
	logic        win0;  // Factor 0 wins arbitration
	logic        wr_ok; // Write completes at this edge

	always_comb begin
		win0 = p0 && (!raw[1] || LEV0 >= LEV1);
		best = win0 ? LEV0 : (raw[1] ? LEV1 : 3'h0);
	end
	// notify only above mask, not while held
	assign dev_req = !held && best > cmask;
	assign dev_level = best;
	// Idle data line shows the inverse of the last value
	assign dev_rdata = dev_ready ? vreg : ~rd_q;
	assign wr_ok = dev_sel && dev_ready && dev_wr;

	// Answers each access after one wait cycle
	always_ff @(posedge core_clk) begin
		dev_ready <= rst_n && dev_sel && !dev_ready;
		prev0 <= raw[0];
		if (!rst_n) begin
			{p0, held, cmask, pmask, vreg, rd_q} <= '0;
		end else begin
			if (raw[0] && !prev0) begin
				p0 <= 1'b1;
			end
			if (dev_ack && !held) begin
				held <= 1'b1;
				pmask <= cmask;
				cmask <= best;
				vreg[7:0] <= win0 ? OFS0 : OFS1;
			end
			if (dev_sel && dev_ready) begin
				rd_q <= vreg;
			end
			if (dev_sel && dev_ready && !dev_wr
				&& dev_addr == `ILVC_DEV_VECTOR) begin
				held <= 1'b0;
			end
			if (wr_ok && dev_addr == `ILVC_DEV_VECTOR) begin
				vreg[31:8] <= dev_wdata[31:8];
			end
			// clear code OFS0 clears factor 0's edge flag; factor 1 is a level and has no flag to clear
			if (wr_ok && dev_addr == `ILVC_DEV_CLEAR
				&& dev_wdata[7:0] == OFS0) begin
				p0 <= 1'b0;
			end
			// mask taken only with select bit
			if (wr_ok && dev_addr == `ILVC_DEV_MASK
				&& dev_wdata[`ILVC_DEV_MSEL]) begin
				cmask <= dev_wdata[2:0];
			end
		end
	end
endmodule : ilvc_dev_model

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "ilvc_cfg.svh"
// Drives the host over APB against the controller model
module testbench;
	import ilvc_pkg::*;
	logic        core_clk = 1'b0; // Starts low
	logic        rst_n, psel, penable, pwrite, pready, pslverr;
	logic        dev_req, dev_ack, dev_sel, dev_wr, dev_ready, err;
	logic [7:0]  paddr, dev_addr;
	logic [31:0] pwdata, prdata, core_pc, dev_wdata, dev_rdata, rd;
	logic [1:0]  raw;       // Factor inputs of the model
	ilvc_level_t dev_level;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          cyc = 0;   // Cycle count for the hang limit

	ilvc_host u_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .core_pc, .dev_req,
		.dev_level, .dev_ack, .dev_sel, .dev_wr, .dev_addr, .dev_wdata,
		.dev_rdata, .dev_ready);
	ilvc_dev_model u_dev (.core_clk, .rst_n, .raw, .dev_ack, .dev_sel,
		.dev_wr, .dev_addr, .dev_wdata, .dev_req, .dev_level,
		.dev_rdata, .dev_ready);

	// Clock of 100 ns period
	always #50 core_clk = ~core_clk;

	// Hang limit
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// Compares a seen value with the expected one
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	// Polls status until the masked bits match
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, `ILVC_REG_STATUS, 32'h0);
			if ((rd & m) === v) break;
		end
	endtask : wait_st

	// Software write to a device register
	task automatic dcmd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, `ILVC_REG_DADDR, {24'h0, a});
		apb(1'b1, `ILVC_REG_DWDATA, d);
		apb(1'b1, `ILVC_REG_DCMD, 32'h0000_0003);
		wait_st(32'h0000_0002, 32'h0);
	endtask : dcmd

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// Main sequence
	initial begin
		{psel, penable, pwrite, raw, rst_n} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		core_pc = 32'h0000_1A20;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, `ILVC_REG_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check({rd[30:0], err}, 32'h1);
		$display("test reset done");
		// Table base, enable, factor 0 edge at level 5
		dcmd(`ILVC_DEV_VECTOR, 32'h0001_2300);
		apb(1'b1, `ILVC_REG_CTRL, 32'h0000_001D);
		raw[0] <= 1'b1;
		wait_st(32'h77, 32'h55);
		check(rd & 32'h7777, 32'h0555);
		apb(1'b0, `ILVC_REG_EPC, 32'h0);
		check(rd, 32'h0000_1A20);
		apb(1'b0, `ILVC_REG_VECTOR, 32'h0);
		check(rd, 32'h0001_2304);
		raw[1] <= 1'b1;
		apb(1'b0, `ILVC_REG_STATUS, 32'h0);
		check(rd & 32'h70, 32'h50);
		check({29'h0, u_dev.cmask}, 32'h5);
		check({31'h0, u_dev.p0}, 32'h0);
		$display("test first acceptance done");
		// Return, lower mask, shadow off, factor 1 at level 3
		core_pc <= 32'h0000_2B30;
		apb(1'b1, `ILVC_REG_CTRL, 32'h0000_011C);
		dcmd(`ILVC_DEV_MASK, 32'h1);
		check({29'h0, u_dev.cmask}, 32'h1);
		apb(1'b1, `ILVC_REG_CTRL, 32'h0000_001F);
		wait_st(32'h77, 32'h35);
		check(rd & 32'h7777, 32'h0035);
		apb(1'b0, `ILVC_REG_EPC, 32'h0);
		check(rd, 32'h0000_2B30);
		apb(1'b0, `ILVC_REG_VECTOR, 32'h0);
		check(rd, 32'h0001_2308);
		check({26'h0, u_dev.pmask, u_dev.cmask}, 32'h0000_000B);
		$display("test second acceptance done");
		// Device write while interrupts are live is refused
		apb(1'b1, `ILVC_REG_CTRL, 32'h0000_011F);
		dcmd(`ILVC_DEV_MASK, 32'h0);
		apb(1'b0, `ILVC_REG_STATUS, 32'h0);
		check(rd & 32'h9, 32'h8);
		check({29'h0, u_dev.cmask}, 32'h3);
		apb(1'b1, `ILVC_REG_STATUS, 32'h0000_0008);
		apb(1'b0, `ILVC_REG_STATUS, 32'h0);
		check(rd & 32'h8, 32'h0);
		$display("test refusal done");
		// Control read back and a device read command
		apb(1'b0, `ILVC_REG_CTRL, 32'h0);
		check(rd, 32'h0000_001F);
		apb(1'b1, `ILVC_REG_DADDR, {24'h0, `ILVC_DEV_VECTOR});
		apb(1'b1, `ILVC_REG_DCMD, 32'h0000_0001);
		wait_st(32'h0000_0002, 32'h0);
		apb(1'b0, `ILVC_REG_DRDATA, 32'h0);
		check(rd, 32'h0001_2308);
		$display("test device read done");
		finish_test();
	end
endmodule : testbench

bind ilvc_host ilvc_host_monitor u_mon (.core_clk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dev_req,
	.dev_ack, .dev_sel, .dev_wr, .dev_addr, .dev_wdata, .dev_ready);
